// ===== verilog/supervisor_cfg.svh
// timing constants and reset values for the supply supervisor
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// clock rate in kHz (8 ns period)
`define CLK_KHZ 125000
// reset pulse, nominal and least, in ms
`define RST_PULSE_MS 200
`define RST_MIN_MS 140
// watchdog timeout in ms
`define WDOG_TIMEOUT_MS 1600
// derived cycle counts
`define RST_PULSE_CYCLES (`RST_PULSE_MS * `CLK_KHZ)
`define RST_MIN_CYCLES (`RST_MIN_MS * `CLK_KHZ)
`define WDOG_TIMEOUT_CYCLES (`WDOG_TIMEOUT_MS * `CLK_KHZ)
// pin sense vector width
`define PIN_COUNT 5
// output values while RESET_N is low
`define RESET_OUT_N_INIT 1'b0
`define PFAIL_OUT_INIT 1'b0
`define WDOG_OUT_INIT 1'b0

`endif

// ===== verilog/supervisor_pkg.sv
// types shared by the supply supervisor files
package supervisor_pkg;

	// synchronised pin levels, one bit each
	typedef struct packed {
		logic manual_reset_n;
		logic supply_low;
		logic power_fail_sense_in;
		logic kick_input;
		logic kick_float;
	} pin_sense_t;

	// reset pulse sequencer
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_HOLD    = 2'b01,
		ST_STRETCH = 2'b10
	} rst_state_t;

endpackage

// ===== verilog/kick_watchdog.sv
// watchdog timer cleared by edges on the kick input
`timescale 1ns/1ns
`default_nettype none
module kick_watchdog #(
	parameter int unsigned TIMEOUT_CYCLES = 200000000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic kick,
	input  wire logic kick_float,
	input  wire logic sys_rst,
	output var  logic timed_out
);
	import supervisor_pkg::*;

	localparam int unsigned CW = $clog2(TIMEOUT_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

	if (TIMEOUT_CYCLES < 2) begin : g_chk
		$error("watchdog timeout must be at least two cycles");
	end

	logic          kick_prev_q;
	logic [CW-1:0] cnt_q;
	logic          timed_out_q;
	logic          edge_seen;
	logic          clear;

	assign edge_seen = kick ^ kick_prev_q;
	// a floating pin gives no edges worth counting
	assign clear = sys_rst | kick_float | (edge_seen & ~kick_float);
	assign timed_out = timed_out_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			kick_prev_q <= 1'b0;
		end else begin
			kick_prev_q <= kick;
		end
	end

	// counts only once reset is gone and the pin is driven
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			cnt_q <= '0;
		end else if (cnt_q != LAST) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// held until a clearing event, timer saturates meanwhile
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			timed_out_q <= 1'b0;
		end else if (cnt_q == LAST) begin
			timed_out_q <= 1'b1;
		end
	end

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_WD_TIMEOUT: assert property (!clear && cnt_q == LAST |=> timed_out_q)
		else $error("no timeout after full idle period");
	AST_WD_FLOAT: assert property (kick_float |=> !timed_out_q && cnt_q == '0)
		else $error("watchdog active while kick pin floats");
	AST_WD_CLEAR: assert property (edge_seen && !kick_float |=> cnt_q == '0)
		else $error("kick edge did not clear the timer");
	AST_WD_STICKY: assert property (timed_out_q && !clear |=> timed_out_q)
		else $error("timeout dropped without a clear");
	AST_WD_START: assert property (!clear && cnt_q != LAST |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("timer did not advance while enabled");
	AST_WD_HOLD_RST: assert property (sys_rst [*2] |=> cnt_q == '0 && !timed_out_q)
		else $error("timer ran during reset");
	CV_WD_TIMEOUT: cover property ($rose(timed_out_q));
	CV_WD_KICKED: cover property (edge_seen && cnt_q > 3);

endmodule
`default_nettype wire

// ===== verilog/supply_supervisor.sv
// supply supervisor: reset pulse, watchdog and power-fail flag
`include "supervisor_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor #(
	parameter int unsigned PULSE_CYCLES   = `RST_PULSE_CYCLES,
	parameter int unsigned MIN_CYCLES     = `RST_MIN_CYCLES,
	parameter int unsigned TIMEOUT_CYCLES = `WDOG_TIMEOUT_CYCLES
) (
	input  wire logic                     SYS_CLK,
	input  wire logic                     RESET_N,
	input  wire supervisor_pkg::pin_sense_t PIN_SENSE,
	output var  logic                     RESET_OUT_N,
	output var  logic                     RESET_OUT,
	output var  logic                     POWER_FAIL_FLAG_OUT,
	output var  logic                     TIMEOUT_FLAG_OUT
);
	import supervisor_pkg::*;

	// ******************************
	// elaboration checks
	// ******************************
	localparam int unsigned PW = $clog2(PULSE_CYCLES);
	localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);

	if (PULSE_CYCLES < 2) begin : g_chk_pulse
		$error("reset pulse must be at least two cycles");
	end
	if (MIN_CYCLES > PULSE_CYCLES || MIN_CYCLES < 1) begin : g_chk_min
		$error("least pulse must be between one and the nominal pulse");
	end
	// the watchdog needs room to count before it trips
	if (TIMEOUT_CYCLES < 2) begin : g_chk_timeout
		$error("watchdog timeout must be at least two cycles");
	end

	// ******************************
	// pin synchronisers
	// ******************************
	logic [`PIN_COUNT-1:0] sync1_q;
	logic [`PIN_COUNT-1:0] sync2_q;
	pin_sense_t            pins;

	// first stage feeds only the second stage
	for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_sync
		always_ff @(posedge SYS_CLK) begin
			if (!RESET_N) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= PIN_SENSE[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end

	assign pins = pin_sense_t'(sync2_q);

	logic mr_low;
	logic uv;
	logic trigger;

	// manual reset is active low
	assign mr_low  = ~pins.manual_reset_n;
	assign uv      = pins.supply_low;
	assign trigger = uv | mr_low;

	// ******************************
	// reset pulse sequencer
	// ******************************
	rst_state_t    state_q;
	rst_state_t    state_d;
	logic [PW-1:0] cnt_q;
	logic [PW-1:0] cnt_d;

	// any trigger keeps the sequencer in hold, and the full
	// pulse restarts on its release; this also covers a
	// brownout in mid-pulse with margin over the least time
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (trigger) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!trigger) begin
					state_d = ST_STRETCH;
					cnt_d   = PULSE_LAST;
				end
			end
			ST_STRETCH: begin
				if (trigger) begin
					state_d = ST_HOLD;
				end else if (cnt_q == '0) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = ST_HOLD;
			end
		endcase
	end

	// power-up behaves like a trigger that has just gone away
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			state_q <= ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// both polarities from the same next state, so they
	// never disagree even for one cycle
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			RESET_OUT_N <= `RESET_OUT_N_INIT;
			RESET_OUT   <= ~`RESET_OUT_N_INIT;
		end else begin
			RESET_OUT_N <= (state_d == ST_IDLE);
			RESET_OUT   <= (state_d != ST_IDLE);
		end
	end

	// ******************************
	// watchdog
	// ******************************
	logic wd_timeout;

	// timeout stays out of the sequencer; only an external
	// loop to the manual reset pin turns it into a reset
	kick_watchdog #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_watchdog (
		.clk        (SYS_CLK),
		.rst_n      (RESET_N),
		.kick       (pins.kick_input),
		.kick_float (pins.kick_float),
		.sys_rst    (~RESET_OUT_N),
		.timed_out  (wd_timeout)
	);

	// no minimum low time on this flag
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			TIMEOUT_FLAG_OUT <= `WDOG_OUT_INIT;
		end else begin
			TIMEOUT_FLAG_OUT <= ~(wd_timeout | uv);
		end
	end

	// ******************************
	// power-fail flag
	// ******************************
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			POWER_FAIL_FLAG_OUT <= `PFAIL_OUT_INIT;
		end else begin
			POWER_FAIL_FLAG_OUT <= pins.power_fail_sense_in;
		end
	end

	// ******************************
	// check helpers
	// ******************************
	localparam int unsigned QW = $clog2(PULSE_CYCLES + 2);
	localparam int unsigned UW = $clog2(MIN_CYCLES + 1);

	logic [QW-1:0] quiet_q;
	logic [UW-1:0] since_uv_q;

	// edges since any trigger was last seen; saturates so a
	// long idle spell cannot wrap back into the pulse window
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			quiet_q <= '0;
		end else if (trigger) begin
			quiet_q <= '0;
		end else if (quiet_q != QW'(PULSE_CYCLES + 1)) begin
			quiet_q <= quiet_q + 1'b1;
		end
	end

	// edges since undervoltage was last seen, for the brownout case
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			since_uv_q <= '0;
		end else if (uv) begin
			since_uv_q <= '0;
		end else if (since_uv_q != UW'(MIN_CYCLES)) begin
			since_uv_q <= since_uv_q + 1'b1;
		end
	end

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	AST_MR_STARTS: assert property (mr_low |=> !RESET_OUT_N)
		else $error("manual reset did not assert reset");

	AST_PFAIL: assert property (##1 POWER_FAIL_FLAG_OUT == $past(pins.power_fail_sense_in))
		else $error("power-fail flag does not follow its input");

	AST_UV_HOLD: assert property (uv |=> !RESET_OUT_N && !TIMEOUT_FLAG_OUT)
		else $error("undervoltage did not hold reset and flag low");

	AST_RELEASE_LEN: assert property ($rose(RESET_OUT_N) |-> $past(state_q) == ST_STRETCH && $past(cnt_q) == '0)
		else $error("reset released before the pulse ran out");

	AST_FULL_PULSE: assert property (state_q == ST_HOLD && !trigger
		|=> state_q == ST_STRETCH && cnt_q == PULSE_LAST)
		else $error("pulse not loaded at full length");

	AST_STRETCH_LOW: assert property (state_q == ST_STRETCH && cnt_q != '0 |=> !RESET_OUT_N)
		else $error("reset rose in mid-pulse");

	AST_NO_WD_RESET: assert property (state_q == ST_IDLE && !trigger && wd_timeout |=> RESET_OUT_N)
		else $error("watchdog timeout asserted reset");

	AST_WDO_FAST: assert property ($fell(uv) && !wd_timeout |=> TIMEOUT_FLAG_OUT)
		else $error("timeout flag delayed after undervoltage");

	AST_WDO_TIMEOUT: assert property (wd_timeout |=> !TIMEOUT_FLAG_OUT)
		else $error("timeout flag high during a timeout");

	AST_COMPLEMENT: assert property (RESET_OUT == !RESET_OUT_N)
		else $error("reset outputs not complementary");

	AST_BROWNOUT_EXT: assert property ($fell(uv) && !mr_low && state_q != ST_IDLE
		|=> state_q == ST_STRETCH && cnt_q >= PW'(MIN_CYCLES - 1))
		else $error("brownout pulse shorter than least time");

	AST_BROWNOUT_MIN: assert property (since_uv_q < UW'(MIN_CYCLES) |=> !RESET_OUT_N)
		else $error("reset released too soon after a brownout");

	AST_QUIET_LOW: assert property (quiet_q < QW'(PULSE_CYCLES) |=> !RESET_OUT_N)
		else $error("reset released before the full pulse");

	AST_QUIET_RELEASE: assert property ($rose(RESET_OUT_N) |-> quiet_q == QW'(PULSE_CYCLES + 1))
		else $error("reset pulse length differs from nominal");

	AST_TRIG_HOLD: assert property (trigger |=> state_q == ST_HOLD)
		else $error("trigger did not hold the sequencer");

	AST_HOLD_LOW: assert property (state_q == ST_HOLD |-> !RESET_OUT_N)
		else $error("reset high while held");

	AST_IDLE_HOLDS: assert property (state_q == ST_IDLE && !trigger |=> state_q == ST_IDLE && RESET_OUT_N)
		else $error("reset left idle without a trigger");

	AST_STRETCH_COUNT: assert property (state_q == ST_STRETCH && !trigger && cnt_q != '0
		|=> cnt_q == $past(cnt_q) - 1'b1)
		else $error("pulse counter did not step down");

	AST_WDO_HIGH: assert property (!wd_timeout && !uv |=> TIMEOUT_FLAG_OUT)
		else $error("timeout flag low without cause");

	AST_WD_IN_RESET: assert property (!RESET_OUT_N |=> !wd_timeout)
		else $error("watchdog not cleared while reset is out");

	AST_PFAIL_LOW: assert property (!pins.power_fail_sense_in |=> !POWER_FAIL_FLAG_OUT)
		else $error("power-fail flag high while input is low");

	CV_MANUAL: cover property (mr_low ##1 !mr_low);
	CV_RELEASE: cover property ($rose(RESET_OUT_N));
	CV_BROWNOUT: cover property (state_q == ST_STRETCH && uv);

endmodule
`default_nettype wire

// ===== verification/kick_host.sv
// processor model that kicks, holds or floats the watchdog line
`timescale 1ns/1ns
`default_nettype none
module kick_host (
	input  wire logic       clk,
	input  wire logic [1:0] mode,
	input  wire logic       rst_out_n,
	output var  logic       kick,
	output var  logic       kick_float
);
	int cnt = 0;
	initial begin
		kick = 1'b0;
		kick_float = 1'b0;
	end
	// mode 0 toggles every 16 cycles while reset out is high, 1 holds, 2 floats
	always @(negedge clk) begin
		cnt = (cnt + 1) % 16;
		kick_float = (mode == 2'd2);
		// a released line shows no stable level, so it wanders
		if (kick_float)
			kick = ~kick;
		else if (mode == 2'd0 && rst_out_n && cnt == 0)
			kick = ~kick;
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// testbench for the supply supervisor against a bench model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin \
	num_checks++; \
	if ((a) !== (b)) begin \
		fail_count++; \
		$display("wrong value at %0t: mismatch", $time); \
	end \
end
module tb;
	import supervisor_pkg::*;
	// short counts keep the run brief
	localparam int PUL = 40;
	localparam int MIN = 28;
	localparam int TO  = 100;
	logic        sys_clk = 0;
	logic        reset_n = 0;
	logic        mr_n = 1;
	logic        uv = 0;
	logic        pfs = 1;
	logic        kick, kflt, rst_n_o, rst_o, pf_o, to_o;
	logic [1:0]  mode = 2'h0;
	logic [31:0] seed = 32'h4cbb_5165;
	pin_sense_t  pin;
	int          fail_count = 0;
	int          num_checks = 0;
	int          n;
	int          up = 0;
	bit          pfq[$];
	assign pin = {mr_n, uv, pfs, kick, kflt};
	always #4 sys_clk = ~sys_clk;
	supply_supervisor #(.PULSE_CYCLES(PUL), .MIN_CYCLES(MIN), .TIMEOUT_CYCLES(TO)) u_supply_supervisor (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .PIN_SENSE(pin), .RESET_OUT_N(rst_n_o),
		.RESET_OUT(rst_o), .POWER_FAIL_FLAG_OUT(pf_o), .TIMEOUT_FLAG_OUT(to_o));
	kick_host u_kick_host (.clk(sys_clk), .mode(mode), .rst_out_n(rst_n_o), .kick(kick), .kick_float(kflt));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ****************
	// bench model
	// ****************
	always @(negedge sys_clk) begin
		seed = lfsr(seed);
		if (seed[2:0] == 3'h0)
			pfs = seed[9];
	end
	// flag is the sensed level a few edges late; only judged once steady
	always @(posedge sys_clk) begin
		pfq.push_back(pfs);
		if (pfq.size() > 4)
			pfq.pop_front();
		up = reset_n ? up + 1 : 0;
		#1;
		if (up > 5) begin
			`CHK(rst_o, ~rst_n_o)
			if (pfq.size() == 4 && pfq[0] == pfq[1] && pfq[1] == pfq[2] && pfq[2] == pfq[3])
				`CHK(pf_o, pfq[0])
		end
	end

	// ****************
	// tasks
	// ****************
	task automatic close_out();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	// edges until reset out (0) or timeout flag (1) reaches lvl
	task automatic wait_for(input int which, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while ((which ? to_o : rst_n_o) !== lvl) begin
			@(posedge sys_clk);
			#1;
			cnt++;
			if (cnt > lim) begin
				fail_count++;
				close_out();
			end
		end
	endtask

	task automatic in_range(input int v, input int lo, input int hi);
		`CHK(v >= lo && v <= hi, 1'b1)
	endtask

	// ****************
	// scenarios
	// ****************
	initial begin
		cyc(8);
		reset_n = 1;
		wait_for(0, 1'b1, PUL + 20, n);
		in_range(n, PUL, PUL + 8);
		cyc(1);
		mr_n = 0;
		cyc(4 + int'(seed[2:0]));
		`CHK(rst_n_o, 1'b0)
		mr_n = 1;
		wait_for(0, 1'b1, PUL + 20, n);
		in_range(n, PUL + 1, PUL + 5);
		cyc(TO + 50);
		`CHK(to_o, 1'b1)
		mode = 2'h1;
		wait_for(1, 1'b0, TO + 40, n);
		in_range(n, TO - 16, TO + 8);
		cyc(20);
		`CHK(to_o, 1'b0)
		`CHK(rst_n_o, 1'b1)
		mode = 2'h0;
		wait_for(1, 1'b1, 30, n);
		`CHK(to_o, 1'b1)
		cyc(1);
		mode = 2'h2;
		cyc(2 * TO);
		`CHK(to_o, 1'b1)
		mode = 2'h0;
		cyc(1);
		uv = 1;
		cyc(4);
		`CHK(to_o, 1'b0)
		cyc(60);
		`CHK(rst_n_o, 1'b0)
		uv = 0;
		cyc(4);
		`CHK(to_o, 1'b1)
		`CHK(rst_n_o, 1'b0)
		wait_for(0, 1'b1, PUL + 20, n);
		in_range(n, PUL - 3, PUL + 1);
		cyc(1);
		mr_n = 0;
		cyc(4);
		mr_n = 1;
		cyc(20);
		uv = 1;
		cyc(3);
		uv = 0;
		wait_for(0, 1'b1, PUL + 20, n);
		in_range(n, MIN, PUL + 5);
		cyc(TO);
		close_out();
	end

	// hang guard
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
